/* File: logic/osc_pll_control.sv */
// Design decision made here: strobed register access.
`timescale 1ns/1ps

// Notes on behaviour
// - Slow oscillator stable flag is status bit 2
// - Fast oscillator stable flag is status bit 1
// - Switch pending until new source stable
// - Fast oscillator runs on request, or kept outside power-down
// - Fast output delivered two cycles after request
// - Frequency field picks fast oscillator output
// - Control bit 0 enables crystal auto-tune
// - Trim is six-bit signed, sign-extended reads
// - Auto-tune on locks trim against software
// - Trim reloads tune result after auto-tune off
// - PLL runs on peripheral request or kept outside power-down, multiplier not off
// - PLL output delivered two cycles after request
// - PLL reference: fast oscillator or external
// - Multiplier: off, times two, times three
// - Slow oscillator runs on request or kept
// - Slow output delivered four cycles after request
// - Crystal runs on request in active or idle, or kept, enabled
// - Crystal output within three cycles after start
// - Start-up field sets crystal wait length
// - Start-up and source bits lock while on
// - Source bit picks crystal or external clock
// - Control bit 1 selects crystal low power
// - Control bit 0 enables crystal, claims pins
// - Stable flags read zero unless requested
module osc_pll_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cfg_unlock,
  input wire logic [1:0] sleep_mode,
  input wire logic hf_main_req,
  input wire logic hf_periph_req,
  input wire logic pll_periph_req,
  input wire logic slow_main_req,
  input wire logic slow_periph_req,
  input wire logic xtal_main_req,
  input wire logic xtal_periph_req,
  input wire logic ext_requested,
  input wire logic hf_ready,
  input wire logic pll_ready,
  input wire logic slow_ready,
  input wire logic ext_ready,
  input wire logic hf_tick,
  input wire logic pll_tick,
  input wire logic slow_tick,
  input wire logic xtal_tick,
  input wire logic [5:0] tune_result,
  input wire logic main_switch_start,
  input wire logic [1:0] main_switch_target,
  output logic hf_osc_run,
  output logic [3:0] hf_freq_choice,
  output logic crystal_trim_enable,
  output logic [5:0] hf_trim,
  output logic pll_run,
  output logic [1:0] pll_multiplier,
  output logic pll_ref_external,
  output logic slow_osc_run,
  output logic crystal_run,
  output logic crystal_low_power,
  output logic crystal_ext_mode,
  output logic crystal_pins_claimed,
  output logic hf_deliver,
  output logic pll_deliver,
  output logic slow_deliver,
  output logic crystal_deliver,
  output logic main_switch_pending
);

  typedef struct packed {
    logic hf_keep;
    logic [3:0] hf_freq;
    logic tune_en;
    logic [5:0] trim;
    logic [8:0] tune_cnt;
    logic pll_keep;
    logic pll_src;
    logic [1:0] pll_mul;
    logic slow_keep;
    logic xt_keep;
    logic [1:0] xt_crystal_startup_count;
    logic xt_sel;
    logic xt_lp;
    logic xt_en;
    clk_ctrl_pkg::xtal_state_t xt_state;
    logic [16:0] xt_cnt;
    logic pending;
    logic [7:0] rdata;
  } ctrl_state_t;

  localparam ctrl_state_t CTRL_RST = '{
    hf_keep: clk_ctrl_pkg::HF_CTRL_RST[clk_ctrl_pkg::KEEP_BIT],
    hf_freq: clk_ctrl_pkg::HF_CTRL_RST[clk_ctrl_pkg::HF_FREQ_LSB +: 4],
    tune_en: clk_ctrl_pkg::HF_CTRL_RST[clk_ctrl_pkg::TUNE_EN_BIT],
    trim: clk_ctrl_pkg::HF_TRIM_RST[5:0],
    tune_cnt: 9'h000,
    pll_keep: clk_ctrl_pkg::PLL_CTRL_RST[clk_ctrl_pkg::KEEP_BIT],
    pll_src: clk_ctrl_pkg::PLL_CTRL_RST[clk_ctrl_pkg::PLL_SRC_BIT],
    pll_mul: clk_ctrl_pkg::PLL_CTRL_RST[clk_ctrl_pkg::MUL_LSB +: 2],
    slow_keep: clk_ctrl_pkg::SLOW_CTRL_RST[clk_ctrl_pkg::KEEP_BIT],
    xt_keep: clk_ctrl_pkg::XTAL_CTRL_RST[clk_ctrl_pkg::KEEP_BIT],
    xt_crystal_startup_count: clk_ctrl_pkg::XTAL_CTRL_RST[clk_ctrl_pkg::CRYSTAL_STARTUP_COUNT_LSB +: 2],
    xt_sel: clk_ctrl_pkg::XTAL_CTRL_RST[clk_ctrl_pkg::XSEL_BIT],
    xt_lp: clk_ctrl_pkg::XTAL_CTRL_RST[clk_ctrl_pkg::XLP_BIT],
    xt_en: clk_ctrl_pkg::XTAL_CTRL_RST[clk_ctrl_pkg::XEN_BIT],
    xt_state: clk_ctrl_pkg::XT_OFF,
    xt_cnt: 17'h00000,
    pending: clk_ctrl_pkg::STATUS_RST[clk_ctrl_pkg::ST_PENDING_BIT],
    rdata: 8'h00
  };

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic deep_sleep;
  logic act_or_idle;
  logic pll_req_live;
  logic hf_req_any;
  logic slow_req_any;
  logic xtal_req_any;
  logic hf_stat;
  logic pll_stat;
  logic slow_stat;
  logic xtal_stat;
  logic ext_stat;
  logic [3:0] src_stable;
  logic [7:0] status_val;
  logic wr_hf_ctrl;
  logic wr_trim;
  logic wr_pll;
  logic wr_slow;
  logic wr_xtal;

  // Power mode qualifiers for the fast and PLL keep-running bits and the crystal request
  assign deep_sleep = (sleep_mode == clk_ctrl_pkg::POWER_DOWN);
  assign act_or_idle = (sleep_mode == clk_ctrl_pkg::ACTIVE)
    || (sleep_mode == clk_ctrl_pkg::IDLE);

  // Who asks for each source; a PLL fed from the fast oscillator asks for it too
  assign pll_req_live = pll_periph_req && (s_q.pll_mul != 2'h0);
  assign hf_req_any = hf_main_req || hf_periph_req || (pll_req_live && !s_q.pll_src);
  assign slow_req_any = slow_main_req || slow_periph_req;
  assign xtal_req_any = xtal_main_req || xtal_periph_req;

  // Run enables toward the analog cores
  assign hf_osc_run = hf_req_any || (s_q.hf_keep && !deep_sleep);
  assign pll_run = (s_q.pll_mul != 2'h0)
    && (pll_periph_req || (s_q.pll_keep && !deep_sleep));
  assign slow_osc_run = slow_req_any || s_q.slow_keep;
  assign crystal_run = s_q.xt_en && ((xtal_req_any && act_or_idle) || s_q.xt_keep);

  // Static controls toward the analog cores
  assign hf_freq_choice = s_q.hf_freq;
  assign crystal_trim_enable = s_q.tune_en;
  assign hf_trim = s_q.trim;
  assign pll_multiplier = (s_q.pll_mul == 2'h3) ? 2'h0 : s_q.pll_mul;
  assign pll_ref_external = s_q.pll_src;
  assign crystal_low_power = s_q.xt_lp;
  assign crystal_ext_mode = s_q.xt_sel;
  assign crystal_pins_claimed = s_q.xt_en;

  // Delivery gates count source cycles; reserved multiplier keeps the PLL dark
  delivery_gate #(.TICKS(clk_ctrl_pkg::HF_DELIVER_TICKS)) u_hf_gate (
    .clk(clk),
    .rst_n(rst_n),
    .request(hf_req_any),
    .running(hf_osc_run && hf_ready),
    .osc_tick(hf_tick),
    .deliver(hf_deliver)
  );

  delivery_gate #(.TICKS(clk_ctrl_pkg::PLL_DELIVER_TICKS)) u_pll_gate (
    .clk(clk),
    .rst_n(rst_n),
    .request(pll_req_live),
    .running(pll_run && pll_ready && (pll_multiplier != 2'h0)),
    .osc_tick(pll_tick),
    .deliver(pll_deliver)
  );

  delivery_gate #(.TICKS(clk_ctrl_pkg::SLOW_DELIVER_TICKS)) u_slow_gate (
    .clk(clk),
    .rst_n(rst_n),
    .request(slow_req_any),
    .running(slow_osc_run && slow_ready),
    .osc_tick(slow_tick),
    .deliver(slow_deliver)
  );

  // The crystal only counts as running once its start-up wait is over
  delivery_gate #(.TICKS(clk_ctrl_pkg::XTAL_DELIVER_TICKS)) u_xtal_gate (
    .clk(clk),
    .rst_n(rst_n),
    .request(xtal_req_any),
    .running(crystal_run && (s_q.xt_state == clk_ctrl_pkg::XT_READY)),
    .osc_tick(xtal_tick),
    .deliver(crystal_deliver)
  );

  // Stable flags are masked by the live request, whatever keep-running says
  assign hf_stat = hf_deliver && hf_req_any;
  assign pll_stat = pll_deliver && pll_req_live;
  assign slow_stat = slow_deliver && slow_req_any;
  assign xtal_stat = crystal_deliver && xtal_req_any;
  assign ext_stat = ext_ready && ext_requested;
  assign src_stable = {ext_stat, xtal_stat, slow_stat, hf_stat};

  always_comb
  begin
    status_val = 8'h00;
    status_val[clk_ctrl_pkg::ST_PENDING_BIT] = s_q.pending;
    status_val[clk_ctrl_pkg::ST_HF_BIT] = hf_stat;
    status_val[clk_ctrl_pkg::ST_SLOW_BIT] = slow_stat;
    status_val[clk_ctrl_pkg::ST_XTAL_BIT] = xtal_stat;
    status_val[clk_ctrl_pkg::ST_EXT_BIT] = ext_stat;
    status_val[clk_ctrl_pkg::ST_PLL_BIT] = pll_stat;
  end

  // Write decode; the trim register is the only unprotected one
  assign wr_hf_ctrl = reg_wr && cfg_unlock && (reg_addr == clk_ctrl_pkg::HF_CTRL_OFS);
  assign wr_trim = reg_wr && (reg_addr == clk_ctrl_pkg::HF_TRIM_OFS);
  assign wr_pll = reg_wr && cfg_unlock && (reg_addr == clk_ctrl_pkg::PLL_CTRL_OFS);
  assign wr_slow = reg_wr && cfg_unlock && (reg_addr == clk_ctrl_pkg::SLOW_CTRL_OFS);
  assign wr_xtal = reg_wr && cfg_unlock && (reg_addr == clk_ctrl_pkg::XTAL_CTRL_OFS);

  // Next state: register writes, trim reload, crystal start-up, switch tracking
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    if (wr_hf_ctrl)
    begin
      s_d.hf_keep = reg_wdata[clk_ctrl_pkg::KEEP_BIT];
      s_d.tune_en = reg_wdata[clk_ctrl_pkg::TUNE_EN_BIT];
      // Reserved codes would leave the oscillator undefined, so they are dropped
      if (clk_ctrl_pkg::freq_code_valid(reg_wdata[clk_ctrl_pkg::HF_FREQ_LSB +: 4]))
      begin
        s_d.hf_freq = reg_wdata[clk_ctrl_pkg::HF_FREQ_LSB +: 4];
      end
    end
    // Trim reload timer: armed on the falling edge of auto-tune
    if (s_q.tune_en && !s_d.tune_en)
    begin
      s_d.tune_cnt = clk_ctrl_pkg::TUNE_LOAD_CYCLES;
    end
    else if (s_d.tune_en)
    begin
      s_d.tune_cnt = 9'h000;
    end
    else if (s_q.tune_cnt != 9'h000)
    begin
      s_d.tune_cnt = s_q.tune_cnt - 9'h001;
    end
    if (wr_trim && !s_q.tune_en)
    begin
      s_d.trim = reg_wdata[5:0];
    end
    if (s_q.tune_cnt == 9'h001)
    begin
      s_d.trim = tune_result;
    end
    if (wr_pll)
    begin
      s_d.pll_keep = reg_wdata[clk_ctrl_pkg::KEEP_BIT];
      s_d.pll_src = reg_wdata[clk_ctrl_pkg::PLL_SRC_BIT];
      s_d.pll_mul = reg_wdata[clk_ctrl_pkg::MUL_LSB +: 2];
    end
    if (wr_slow)
    begin
      s_d.slow_keep = reg_wdata[clk_ctrl_pkg::KEEP_BIT];
    end
    if (wr_xtal)
    begin
      s_d.xt_keep = reg_wdata[clk_ctrl_pkg::KEEP_BIT];
      s_d.xt_lp = reg_wdata[clk_ctrl_pkg::XLP_BIT];
      s_d.xt_en = reg_wdata[clk_ctrl_pkg::XEN_BIT];
      // Changing the wait or the source under a live crystal would corrupt start-up
      if (!s_q.xt_en && !xtal_stat)
      begin
        s_d.xt_crystal_startup_count = reg_wdata[clk_ctrl_pkg::CRYSTAL_STARTUP_COUNT_LSB +: 2];
        s_d.xt_sel = reg_wdata[clk_ctrl_pkg::XSEL_BIT];
      end
    end
    // Crystal start-up: the wait only applies to a real crystal
    unique case (s_q.xt_state)
      clk_ctrl_pkg::XT_OFF:
      begin
        s_d.xt_cnt = 17'h00000;
        if (crystal_run)
        begin
          s_d.xt_state = s_q.xt_sel ? clk_ctrl_pkg::XT_READY : clk_ctrl_pkg::XT_WAIT;
        end
      end
      clk_ctrl_pkg::XT_WAIT:
      begin
        if (!crystal_run)
        begin
          s_d.xt_state = clk_ctrl_pkg::XT_OFF;
        end
        else if (xtal_tick)
        begin
          if (s_q.xt_cnt == clk_ctrl_pkg::startup_last(s_q.xt_crystal_startup_count))
          begin
            s_d.xt_state = clk_ctrl_pkg::XT_READY;
          end
          else
          begin
            s_d.xt_cnt = s_q.xt_cnt + 17'h00001;
          end
        end
      end
      clk_ctrl_pkg::XT_READY:
      begin
        if (!crystal_run)
        begin
          s_d.xt_state = clk_ctrl_pkg::XT_OFF;
        end
      end
      default:
      begin
        s_d.xt_state = clk_ctrl_pkg::XT_OFF;
      end
    endcase
    // A new switch request wins over completion in the same cycle
    if (main_switch_start)
    begin
      s_d.pending = 1'b1;
    end
    else if (s_q.pending && src_stable[main_switch_target])
    begin
      s_d.pending = 1'b0;
    end
    // Read data, one cycle after the strobe; unmapped addresses read zero
    if (reg_rd)
    begin
      unique case (reg_addr)
        clk_ctrl_pkg::STATUS_OFS: s_d.rdata = status_val;
        clk_ctrl_pkg::HF_CTRL_OFS: s_d.rdata = {s_q.hf_keep, 1'b0, s_q.hf_freq, 1'b0, s_q.tune_en};
        clk_ctrl_pkg::HF_TRIM_OFS: s_d.rdata = {{2{s_q.trim[clk_ctrl_pkg::TRIM_SIGN_BIT]}},
                                                s_q.trim};
        clk_ctrl_pkg::PLL_CTRL_OFS: s_d.rdata = {s_q.pll_keep, s_q.pll_src, 4'h0, s_q.pll_mul};
        clk_ctrl_pkg::SLOW_CTRL_OFS: s_d.rdata = {s_q.slow_keep, 7'h00};
        clk_ctrl_pkg::XTAL_CTRL_OFS: s_d.rdata = {s_q.xt_keep, 1'b0, s_q.xt_crystal_startup_count, 1'b0,
                                                  s_q.xt_sel, s_q.xt_lp, s_q.xt_en};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= CTRL_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign main_switch_pending = s_q.pending;

  // Checks on the register side and the status flags
  a_trim_sw_lock: assert property (
    @(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == clk_ctrl_pkg::HF_TRIM_OFS && s_q.tune_en) |=> $stable(s_q.trim))
    else $error("trim changed by software while auto-tune on");

  a_trim_reload_arm: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(s_q.tune_en) |-> (s_q.tune_cnt == clk_ctrl_pkg::TUNE_LOAD_CYCLES))
    else $error("trim reload not armed after auto-tune off");

  a_trim_reload_val: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_q.tune_cnt == 9'h001 && !s_q.tune_en) |=> (s_q.trim == $past(tune_result)))
    else $error("trim not loaded with tune result");

  a_trim_sign_ext: assert property (
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == clk_ctrl_pkg::HF_TRIM_OFS)
      |=> (reg_rdata[7] == reg_rdata[5]) && (reg_rdata[6] == reg_rdata[5]))
    else $error("trim read not sign extended");

  a_switch_done: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_q.pending && src_stable[main_switch_target] && !main_switch_start) |=> !main_switch_pending)
    else $error("switch pending not cleared on stable source");

  a_switch_start: assert property (
    @(posedge clk) disable iff (!rst_n)
    main_switch_start |=> main_switch_pending)
    else $error("switch pending not set on start");

  a_prot_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    (reg_wr && !cfg_unlock && reg_addr == clk_ctrl_pkg::PLL_CTRL_OFS)
      |=> $stable({s_q.pll_keep, s_q.pll_src, s_q.pll_mul}))
    else $error("protected write taken without unlock");

  a_xtal_fields_ro: assert property (
    @(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == clk_ctrl_pkg::XTAL_CTRL_OFS && s_q.xt_en)
      |=> $stable({s_q.xt_crystal_startup_count, s_q.xt_sel}))
    else $error("start-up or source bit changed while enabled");

  a_hf_stat_masked: assert property (
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == clk_ctrl_pkg::STATUS_OFS && !hf_req_any) |=> !reg_rdata[1])
    else $error("fast stable flag read one without request");

  a_pll_off_code: assert property (
    @(posedge clk) disable iff (!rst_n)
    (s_q.pll_mul == 2'h0) |-> !pll_run ##1 !pll_deliver)
    else $error("pll running with multiplier off");

endmodule : osc_pll_control

/* File: pkg/clk_ctrl_pkg.sv */
package clk_ctrl_pkg;

  // Register offsets, byte addresses
  localparam logic [7:0] STATUS_OFS = 8'h03;
  localparam logic [7:0] HF_CTRL_OFS = 8'h08;
  localparam logic [7:0] HF_TRIM_OFS = 8'h09;
  localparam logic [7:0] PLL_CTRL_OFS = 8'h10;
  localparam logic [7:0] SLOW_CTRL_OFS = 8'h18;
  localparam logic [7:0] XTAL_CTRL_OFS = 8'h1C;

  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] HF_CTRL_RST = 8'h0C;
  localparam logic [7:0] HF_TRIM_RST = 8'h00;
  localparam logic [7:0] PLL_CTRL_RST = 8'h00;
  localparam logic [7:0] SLOW_CTRL_RST = 8'h00;
  localparam logic [7:0] XTAL_CTRL_RST = 8'h00;

  // Field positions
  localparam int KEEP_BIT = 7;
  localparam int PLL_SRC_BIT = 6;
  localparam int HF_FREQ_LSB = 2;
  localparam int TUNE_EN_BIT = 0;
  localparam int TRIM_SIGN_BIT = 5;
  localparam int MUL_LSB = 0;
  localparam int CRYSTAL_STARTUP_COUNT_LSB = 4;
  localparam int XSEL_BIT = 2;
  localparam int XLP_BIT = 1;
  localparam int XEN_BIT = 0;
  localparam int ST_PENDING_BIT = 0;
  localparam int ST_HF_BIT = 1;
  localparam int ST_SLOW_BIT = 2;
  localparam int ST_XTAL_BIT = 3;
  localparam int ST_EXT_BIT = 4;
  localparam int ST_PLL_BIT = 5;

  // Oscillator cycles from request to delivery
  localparam logic [2:0] HF_DELIVER_TICKS = 3'h2;
  localparam logic [2:0] PLL_DELIVER_TICKS = 3'h2;
  localparam logic [2:0] SLOW_DELIVER_TICKS = 3'h4;
  localparam logic [2:0] XTAL_DELIVER_TICKS = 3'h3;

  // Crystal start-up lengths in crystal cycles
  localparam logic [16:0] XT_START_1K = 17'h00400;
  localparam logic [16:0] XT_START_16K = 17'h04000;
  localparam logic [16:0] XT_START_32K = 17'h08000;
  localparam logic [16:0] XT_START_64K = 17'h10000;

  // Trim reload delay after auto-tune is switched off
  localparam int CLK_PERIOD_NS = 10;
  localparam int TUNE_SETTLE_NS = 3000;
  localparam int TUNE_EXTRA_CLKS = 3;
  localparam logic [8:0] TUNE_LOAD_CYCLES =
    9'(TUNE_SETTLE_NS / CLK_PERIOD_NS + TUNE_EXTRA_CLKS);

  typedef enum logic [1:0] {
    ACTIVE = 2'b00,
    IDLE = 2'b01,
    STANDBY = 2'b10,
    POWER_DOWN = 2'b11
  } sleep_mode_t;

  typedef enum logic [1:0] {
    XT_OFF = 2'b00,
    XT_WAIT = 2'b01,
    XT_READY = 2'b10
  } xtal_state_t;

  // Last count value of the crystal start-up wait
  function automatic logic [16:0] startup_last(input logic [1:0] code);
    logic [16:0] len;
    unique case (code)
      2'h0: len = XT_START_1K;
      2'h1: len = XT_START_16K;
      2'h2: len = XT_START_32K;
      2'h3: len = XT_START_64K;
    endcase
    return len - 17'h00001;
  endfunction : startup_last

  // Frequency codes that name a real output
  function automatic logic freq_code_valid(input logic [3:0] code);
    return (code <= 4'h3) || ((code >= 4'h5) && (code <= 4'h9));
  endfunction : freq_code_valid

endpackage : clk_ctrl_pkg

/* File: logic/delivery_gate.sv */
`timescale 1ns/1ps

// Passes a running source to its requester a fixed number of source cycles
// after the request; drops on the next clock when the request or the source goes away.
module delivery_gate #(
  parameter logic [2:0] TICKS = 3'h2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic request,
  input wire logic running,
  input wire logic osc_tick,
  output logic deliver
);

  typedef struct packed {
    logic [2:0] cnt;
    logic grant;
  } gate_state_t;

  localparam gate_state_t GATE_RST = '{cnt: 3'h0, grant: 1'b0};

  gate_state_t s_q;
  gate_state_t s_d;

  // Count source cycles while requested and running
  always_comb
  begin
    s_d = s_q;
    if (!(request && running))
    begin
      s_d = GATE_RST;
    end
    else if (!s_q.grant && osc_tick)
    begin
      if (s_q.cnt == TICKS - 3'h1)
      begin
        s_d.grant = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= GATE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign deliver = s_q.grant;

endmodule : delivery_gate

/* File: testbench/osc_analog_model.sv */
`timescale 1ns/1ps

// Analog cores: ready one cycle after run, ticks only while running
module osc_analog_model (
  input wire logic clk,
  input wire logic hf_osc_run,
  input wire logic pll_run,
  input wire logic slow_osc_run,
  input wire logic crystal_run,
  output logic hf_ready,
  output logic pll_ready,
  output logic slow_ready,
  output logic ext_ready,
  output logic hf_tick,
  output logic pll_tick,
  output logic slow_tick,
  output logic xtal_tick,
  output logic [5:0] tune_result
);
  logic [1:0] cnt_q = 2'h0;

  // Short start-up keeps the run brief; ready follows run one cycle late
  always_ff @(posedge clk)
  begin
    cnt_q <= cnt_q + 2'h1;
    hf_ready <= hf_osc_run;
    pll_ready <= pll_run;
    slow_ready <= slow_osc_run;
    ext_ready <= 1'b1;
  end

  // Slow core at quarter rate, others at half; a stopped core never ticks
  assign hf_tick = hf_osc_run & cnt_q[0];
  assign pll_tick = pll_run & cnt_q[0];
  assign slow_tick = slow_osc_run & (cnt_q == 2'h3);
  assign xtal_tick = crystal_run & cnt_q[0];
  // Fixed tune outcome with the sign bit set, so sign extension shows
  assign tune_result = 6'h2A;
endmodule : osc_analog_model

/* File: testbench/tb_osc_pll_control.sv */
`timescale 1ns/1ps

module tb_osc_pll_control;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cfg_unlock = 1'b1;
  logic main_switch_start = 1'b0;
  logic [1:0] sleep_mode = 2'h0;
  logic [1:0] main_switch_target = 2'h0;
  logic hf_main_req = 1'b0, hf_periph_req = 1'b0, pll_periph_req = 1'b0, slow_main_req = 1'b0;
  logic slow_periph_req = 1'b0, xtal_main_req = 1'b0, xtal_periph_req = 1'b0;
  logic ext_requested = 1'b0;
  logic [7:0] reg_rdata;
  logic [5:0] tune_result, hf_trim;
  logic [3:0] hf_freq_choice;
  logic [1:0] pll_multiplier;
  logic hf_ready, pll_ready, slow_ready, ext_ready, hf_tick, pll_tick, slow_tick, xtal_tick;
  logic hf_osc_run, pll_run, slow_osc_run, crystal_run, crystal_trim_enable, pll_ref_external;
  logic crystal_low_power, crystal_ext_mode, crystal_pins_claimed, main_switch_pending;
  logic hf_deliver, pll_deliver, slow_deliver, crystal_deliver;
  int fail_count = 0;
  int total_checks = 0;

  osc_pll_control i_osc_pll_control (.*);
  osc_analog_model i_osc_analog_model (.*);

  always #5 clk = ~clk;

  // Byte compare; a mismatch is reported at once
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bus write; returns after the taking edge has settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Bus read; data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rc

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // Bounded wait; an unknown never counts as high, a lapse ends the run
  task automatic wait_hi(input int s, input int lim);
    logic v;
    for (int n = 0; n <= lim; n++)
    begin
      v = (s == 0) ? hf_deliver : (s == 1) ? pll_deliver : (s == 2) ? slow_deliver
        : (s == 3) ? crystal_deliver : !main_switch_pending;
      if (v === 1'b1)
        return;
      @(posedge clk);
      #1;
    end
    chk(8'h00, 8'h01);
    conclude();
  endtask : wait_hi

  task automatic t_regs();
    logic [7:0] a[7] = '{8'h03, 8'h08, 8'h09, 8'h10, 8'h18, 8'h1C, 8'h05};
    logic [7:0] e[7] = '{8'h00, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++)
      rc(a[i], e[i]);
    wr(8'h03, 8'hFF);
    rc(8'h03, 8'h00);
    $display("reset values done");
  endtask : t_regs

  task automatic t_trim();
    wr(8'h09, 8'h25);
    rc(8'h09, 8'hE5);
    wr(8'h09, 8'hDA);
    rc(8'h09, 8'h1A);
    wr(8'h08, 8'h0D);
    chk({7'h00, crystal_trim_enable}, 8'h01);
    wr(8'h09, 8'h05);
    rc(8'h09, 8'h1A);
    wr(8'h08, 8'h0C);
    repeat (280) @(posedge clk);
    rc(8'h09, 8'h1A);
    repeat (20) @(posedge clk);
    rc(8'h09, 8'hEA);
    chk({2'h0, hf_trim}, 8'h2A);
    $display("trim done");
  endtask : t_trim

  // Reserved codes must leave the last good choice in place
  task automatic t_freq();
    logic [3:0] e;
    e = 4'h3;
    for (int c = 0; c < 16; c++)
    begin
      if (c <= 3 || (c >= 5 && c <= 9))
        e = 4'(c);
      wr(8'h08, {2'b00, 4'(c), 2'b00});
      chk({4'h0, hf_freq_choice}, {4'h0, e});
    end
    $display("frequency codes done");
  endtask : t_freq

  task automatic t_pll();
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h10, {6'b010000, 2'(m)});
      chk({6'h00, pll_multiplier}, (m == 3) ? 8'h00 : 8'(m));
      chk({7'h00, pll_ref_external}, 8'h01);
    end
    wr(8'h10, 8'h41);
    @(posedge clk);
    pll_periph_req <= 1'b1;
    wait_hi(1, 100);
    rc(8'h03, 8'h20);
    wr(8'h10, 8'h01);
    chk({7'h00, hf_osc_run}, 8'h01);
    @(posedge clk);
    pll_periph_req <= 1'b0;
    @(posedge clk);
    #1;
    chk({6'h00, pll_run, pll_deliver}, 8'h00);
    $display("pll done");
  endtask : t_pll

  task automatic t_run();
    @(posedge clk);
    hf_main_req <= 1'b1;
    slow_periph_req <= 1'b1;
    wait_hi(0, 50);
    wait_hi(2, 100);
    rc(8'h03, 8'h06);
    @(posedge clk);
    hf_main_req <= 1'b0;
    slow_periph_req <= 1'b0;
    wr(8'h18, 8'h80);
    wr(8'h08, 8'h8C);
    chk({6'h00, hf_osc_run, slow_osc_run}, 8'h03);
    rc(8'h03, 8'h00);
    @(posedge clk);
    sleep_mode <= 2'h3;
    @(posedge clk);
    #1;
    chk({6'h00, hf_osc_run, slow_osc_run}, 8'h01);
    @(posedge clk);
    sleep_mode <= 2'h0;
    cfg_unlock <= 1'b0;
    wr(8'h18, 8'h00);
    rc(8'h18, 8'h80);
    wr(8'h09, 8'h11);
    rc(8'h09, 8'h11);
    @(posedge clk);
    cfg_unlock <= 1'b1;
    ext_requested <= 1'b1;
    rc(8'h03, 8'h10);
    @(posedge clk);
    ext_requested <= 1'b0;
    $display("run and lock done");
  endtask : t_run

  // Switch to slow, then to crystal while it is still off
  task automatic t_switch();
    for (int k = 1; k < 3; k++)
    begin
      @(posedge clk);
      slow_main_req <= 1'b1;
      main_switch_target <= 2'(k);
      main_switch_start <= 1'b1;
      @(posedge clk);
      main_switch_start <= 1'b0;
      #1;
      chk({7'h00, main_switch_pending}, 8'h01);
      if (k == 1)
        wait_hi(4, 100);
    end
    repeat (20) @(posedge clk);
    #1;
    chk({7'h00, main_switch_pending}, 8'h01);
    $display("switch done");
  endtask : t_switch

  task automatic t_xtal();
    wr(8'h1C, 8'h03);
    chk({5'h00, crystal_ext_mode, crystal_low_power, crystal_pins_claimed}, 8'h03);
    wr(8'h1C, 8'h37);
    rc(8'h1C, 8'h03);
    @(posedge clk);
    xtal_periph_req <= 1'b1;
    @(posedge clk);
    #1;
    chk({7'h00, crystal_run}, 8'h01);
    repeat (1900) @(posedge clk);
    #1;
    chk({7'h00, crystal_deliver}, 8'h00);
    wait_hi(3, 300);
    wait_hi(4, 10);
    rc(8'h03, 8'h0C);
    wr(8'h1C, 8'h83);
    @(posedge clk);
    xtal_periph_req <= 1'b0;
    @(posedge clk);
    xtal_periph_req <= 1'b1;
    #1;
    wait_hi(3, 10);
    wr(8'h1C, 8'h03);
    @(posedge clk);
    sleep_mode <= 2'h2;
    @(posedge clk);
    #1;
    chk({7'h00, crystal_run}, 8'h00);
    @(posedge clk);
    sleep_mode <= 2'h0;
    xtal_periph_req <= 1'b0;
    wr(8'h1C, 8'h00);
    wr(8'h1C, 8'h34);
    rc(8'h1C, 8'h34);
    chk({7'h00, crystal_ext_mode}, 8'h01);
    $display("crystal done");
  endtask : t_xtal

  // Reset held four cycles, then the scenarios in turn
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_trim();
    t_freq();
    t_pll();
    t_run();
    t_switch();
    t_xtal();
    conclude();
  end
endmodule : tb_osc_pll_control
